// file: shared/lfd_pkg.sv
package lfd_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned BAUD_DEF     = 19_200;
  localparam logic [15:0] BITDIV_RST   = 16'(CLK_HZ / BAUD_DEF);
  localparam int unsigned WAKE_MIN_NS  = 150_000;
  localparam int unsigned WAKE_MIN_CYC = (WAKE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned BRK_BITS     = 11;
  localparam int unsigned GAP_BITS     = 10;
  localparam logic [7:0]  SYNC_BYTE    = 8'h55;
  localparam logic [3:0]  MAX_BYTES    = 4'h9;
  localparam logic [5:0]  ID_DIAG_LO   = 6'h3C;
  localparam logic [5:0]  ID_DIAG_HI   = 6'h3D;

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_BITDIV   = 8'h04;
  localparam logic [7:0]  OFS_IDCFG    = 8'h08;
  localparam logic [7:0]  OFS_PAT_LO   = 8'h0C;
  localparam logic [7:0]  OFS_PAT_HI   = 8'h10;
  localparam logic [7:0]  OFS_PMSK_LO  = 8'h14;
  localparam logic [7:0]  OFS_PMSK_HI  = 8'h18;
  localparam logic [7:0]  OFS_STATUS   = 8'h1C;
  localparam logic [7:0]  OFS_MASK     = 8'h20;
  localparam logic [7:0]  OFS_LAST     = 8'h24;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] IDCFG_RST    = 32'h0000_3F00;
  localparam logic [31:0] ZERO_RST     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN      = 0;
  localparam int unsigned CTRL_MODE    = 1;
  localparam int unsigned CTRL_VER     = 4;
  localparam int unsigned CTRL_ERR     = 7;
  localparam int unsigned ID_VAL       = 0;
  localparam int unsigned ID_MSK       = 8;
  localparam int unsigned ID_CND       = 16;
  localparam int unsigned ID_DLEN      = 24;
  localparam int unsigned ID_DNE       = 28;
  localparam int unsigned ST_FRAME     = 0;
  localparam int unsigned ST_ID        = 1;
  localparam int unsigned ST_DATA      = 2;
  localparam int unsigned ST_WAKE      = 3;
  localparam int unsigned ST_CHK       = 4;
  localparam int unsigned ST_PAR       = 5;
  localparam int unsigned ST_SYNC      = 6;
  localparam int unsigned ST_TRIG      = 7;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [2:0]  MODE_FRAME   = 3'h0;
  localparam logic [2:0]  MODE_WAKE    = 3'h1;
  localparam logic [2:0]  MODE_ERROR   = 3'h2;
  localparam logic [2:0]  MODE_ID      = 3'h3;
  localparam logic [2:0]  MODE_IDDATA  = 3'h4;
  localparam logic [2:0]  VER_13       = 3'h0;
  localparam logic [2:0]  VER_20       = 3'h1;
  localparam logic [2:0]  VER_21       = 3'h2;
  localparam logic [2:0]  VER_SAE      = 3'h3;
  localparam logic [2:0]  VER_ANY      = 3'h4;
  localparam logic [1:0]  CND_EQ       = 2'h0;
  localparam logic [1:0]  CND_NE       = 2'h1;
  localparam logic [1:0]  CND_GT       = 2'h2;
  localparam logic [1:0]  CND_LT       = 2'h3;

  typedef enum logic [1:0] {FS_IDLE, FS_SYNC, FS_PID, FS_DATA} lfd_fstate_t;

endpackage

// file: verilog/lfd_monitor.sv
`timescale 1ns/1ps
module lfd_monitor #(
  parameter int unsigned WAKE_MIN_CYC = lfd_pkg::WAKE_MIN_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        lin_rx,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  output logic             trig,
  output logic      [7:0]  byte_data,
  output logic             byte_valid
);

  // ----------------------------------------------------------------
  // reset release and line synchroniser
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [2:0] rx_sync;
  logic       lvl;
  logic       lvl_q;
  logic [23:0] run;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rst_sync <= 2'b00;
    else         rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync <= 3'b111;
      lvl     <= 1'b1;
      lvl_q   <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], lin_rx};
      if (rx_sync[1] == rx_sync[2]) lvl <= rx_sync[2];
      lvl_q   <= lvl;
    end
  end

  // cycles since the last level change, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)              run <= 24'h00_0000;
    else if (lvl != lvl_q)   run <= 24'h00_0001;
    else if (run != 24'hFF_FFFF) run <= run + 24'h00_0001;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl, idcfg, pat_lo, pat_hi, pmsk_lo, pmsk_hi, mask;
  logic [15:0] bitdiv;
  logic [7:0]  status;
  logic [7:0]  ev;

  wire         en      = ctrl[lfd_pkg::CTRL_EN];
  wire [2:0]   mode    = ctrl[lfd_pkg::CTRL_MODE +: 3];
  wire [2:0]   ver     = ctrl[lfd_pkg::CTRL_VER +: 3];
  wire [2:0]   err_sel = ctrl[lfd_pkg::CTRL_ERR +: 3];
  wire [5:0]   id_val  = idcfg[lfd_pkg::ID_VAL +: 6];
  wire [5:0]   id_msk  = idcfg[lfd_pkg::ID_MSK +: 6];
  wire [1:0]   id_cnd  = idcfg[lfd_pkg::ID_CND +: 2];
  wire [3:0]   dlen    = idcfg[lfd_pkg::ID_DLEN +: 4];
  wire         dne     = idcfg[lfd_pkg::ID_DNE];
  wire [63:0]  pat     = {pat_hi, pat_lo};
  wire [63:0]  pmsk    = {pmsk_hi, pmsk_lo};

  wire wr_ctrl   = reg_wr && reg_addr == lfd_pkg::OFS_CTRL;
  wire wr_bitdiv = reg_wr && reg_addr == lfd_pkg::OFS_BITDIV;
  wire wr_idcfg  = reg_wr && reg_addr == lfd_pkg::OFS_IDCFG;
  wire wr_pat_lo = reg_wr && reg_addr == lfd_pkg::OFS_PAT_LO;
  wire wr_pat_hi = reg_wr && reg_addr == lfd_pkg::OFS_PAT_HI;
  wire wr_pm_lo  = reg_wr && reg_addr == lfd_pkg::OFS_PMSK_LO;
  wire wr_pm_hi  = reg_wr && reg_addr == lfd_pkg::OFS_PMSK_HI;
  wire wr_status = reg_wr && reg_addr == lfd_pkg::OFS_STATUS;
  wire wr_mask   = reg_wr && reg_addr == lfd_pkg::OFS_MASK;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= lfd_pkg::CTRL_RST;
      bitdiv  <= lfd_pkg::BITDIV_RST;
      idcfg   <= lfd_pkg::IDCFG_RST;
      pat_lo  <= lfd_pkg::ZERO_RST;
      pat_hi  <= lfd_pkg::ZERO_RST;
      pmsk_lo <= lfd_pkg::ZERO_RST;
      pmsk_hi <= lfd_pkg::ZERO_RST;
      mask    <= lfd_pkg::ZERO_RST;
    end else begin
      if (wr_ctrl)   ctrl    <= reg_wdata;
      if (wr_bitdiv) bitdiv  <= reg_wdata[15:0];
      if (wr_idcfg)  idcfg   <= reg_wdata;
      if (wr_pat_lo) pat_lo  <= reg_wdata;
      if (wr_pat_hi) pat_hi  <= reg_wdata;
      if (wr_pm_lo)  pmsk_lo <= reg_wdata;
      if (wr_pm_hi)  pmsk_hi <= reg_wdata;
      if (wr_mask)   mask    <= reg_wdata;
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  wire [7:0] st_clr = wr_status ? reg_wdata[7:0] : 8'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 8'h00;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~st_clr) | ev;
      irq    <= |(status & mask[7:0]);
    end
  end

  // ----------------------------------------------------------------
  // byte receiver
  // ----------------------------------------------------------------
  logic        rx_busy;
  logic [15:0] rx_cnt;
  logic [3:0]  bit_idx;
  logic [7:0]  shreg;

  wire fell      = lvl_q && !lvl;
  wire rose      = !lvl_q && lvl;
  wire rx_start  = en && !rx_busy && fell;
  wire samp      = rx_busy && rx_cnt == 16'h0000;
  wire bad_start = samp && bit_idx == 4'h0 && lvl;
  wire byte_done = samp && bit_idx == 4'h9;
  wire byte_ok   = byte_done && lvl;
  wire data_bit  = bit_idx != 4'h0 && bit_idx != 4'h9;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy <= 1'b0;
      rx_cnt  <= 16'h0000;
      bit_idx <= 4'h0;
      shreg   <= 8'h00;
    end else if (rx_start) begin
      rx_busy <= 1'b1;
      rx_cnt  <= {1'b0, bitdiv[15:1]};
      bit_idx <= 4'h0;
    end else if (samp) begin
      rx_cnt  <= bitdiv - 16'h0001;
      bit_idx <= bit_idx + 4'h1;
      if (data_bit) shreg <= {lvl, shreg[7:1]};
      if (byte_done || bad_start) rx_busy <= 1'b0;
    end else if (rx_busy) begin
      rx_cnt  <= rx_cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
    end else begin
      byte_valid <= byte_ok;
      if (byte_ok) byte_data <= shreg;
    end
  end

  // ----------------------------------------------------------------
  // frame decoding
  // ----------------------------------------------------------------
  function automatic logic [1:0] lfd_parity(input logic [5:0] i);
    lfd_parity = {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4]};
  endfunction

  function automatic logic [7:0] lfd_addc(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    lfd_addc = s[7:0] + {7'h00, s[8]};
  endfunction

  lfd_pkg::lfd_fstate_t fs;
  logic [7:0] pid_q, sum_cls, sum_enh, prev_cls, prev_enh, last_byte;
  logic [3:0] nbytes;
  logic       id_hit_q, data_ok_q;

  wire [23:0] bd24    = {8'h00, bitdiv};
  wire [23:0] brk_thr = bd24 * 24'(lfd_pkg::BRK_BITS);
  wire [23:0] gap_thr = bd24 * 24'(lfd_pkg::GAP_BITS);
  wire        brk     = en && rose && run >= brk_thr;
  wire        ev_wake = en && rose && fs == lfd_pkg::FS_IDLE
                        && run >= 24'(WAKE_MIN_CYC) && run < brk_thr;

  wire        par_ok  = shreg[7:6] == lfd_parity(shreg[5:0]);
  wire [5:0]  id_rx   = shreg[5:0] & id_msk;
  wire [5:0]  id_ref  = id_val & id_msk;
  wire        id_hit  = id_cnd == lfd_pkg::CND_EQ ? id_rx == id_ref :
                        id_cnd == lfd_pkg::CND_NE ? id_rx != id_ref :
                        id_cnd == lfd_pkg::CND_GT ? id_rx >  id_ref :
                                                    id_rx <  id_ref;

  wire [5:0]  pos     = {nbytes[2:0], 3'b000};
  wire [7:0]  pat_b   = pat[pos +: 8];
  wire [7:0]  msk_b   = pmsk[pos +: 8];
  wire        byte_hit = ((shreg ^ pat_b) & msk_b) == 8'h00;
  wire        all_hit = data_ok_q && byte_hit;
  wire        full    = nbytes == lfd_pkg::MAX_BYTES;
  wire        brk_byte = byte_done && !lvl && shreg == 8'h00;
  wire        in_frame = fs == lfd_pkg::FS_PID || fs == lfd_pkg::FS_DATA;
  wire        gap     = !rx_busy && lvl && run == gap_thr;
  wire        end_frame = fs == lfd_pkg::FS_DATA && (gap || full || brk_byte);

  wire        cls_id  = pid_q[5:0] == lfd_pkg::ID_DIAG_LO || pid_q[5:0] == lfd_pkg::ID_DIAG_HI;
  wire        ok_cls  = last_byte == ~prev_cls;
  wire        ok_enh  = last_byte == ~prev_enh;
  wire        chk_ok  = ver == lfd_pkg::VER_ANY ? (ok_cls || ok_enh) :
                        (ver == lfd_pkg::VER_13 || cls_id) ? ok_cls : ok_enh;

  wire ev_frame = fs == lfd_pkg::FS_SYNC && byte_ok && shreg == lfd_pkg::SYNC_BYTE;
  wire ev_id    = fs == lfd_pkg::FS_PID && byte_ok && id_hit;
  wire ev_par   = fs == lfd_pkg::FS_PID && byte_ok && !par_ok;
  wire ev_data  = fs == lfd_pkg::FS_DATA && byte_ok && !full && id_hit_q
                  && nbytes + 4'h1 == dlen && (dne ? !all_hit : all_hit);
  wire ev_chk   = end_frame && nbytes >= 4'h2 && !chk_ok;
  wire ev_sync  = (fs == lfd_pkg::FS_SYNC && byte_done && !ev_frame)
                  || (in_frame && byte_done && !lvl && shreg != 8'h00);

  wire [2:0] err_ev = {ev_sync, ev_par, ev_chk};
  wire trig_ev = mode == lfd_pkg::MODE_FRAME  ? ev_frame :
                 mode == lfd_pkg::MODE_WAKE   ? ev_wake :
                 mode == lfd_pkg::MODE_ERROR  ? |(err_ev & err_sel) :
                 mode == lfd_pkg::MODE_ID     ? ev_id :
                 mode == lfd_pkg::MODE_IDDATA ? ev_data : 1'b0;

  assign ev = {trig_ev, ev_sync, ev_par, ev_chk, ev_wake, ev_data, ev_id, ev_frame};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) trig <= 1'b0;
    else        trig <= trig_ev;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)   fs <= lfd_pkg::FS_IDLE;
    else if (!en) fs <= lfd_pkg::FS_IDLE;
    else if (brk) fs <= lfd_pkg::FS_SYNC;
    else begin
      case (fs)
        lfd_pkg::FS_IDLE: fs <= lfd_pkg::FS_IDLE;
        lfd_pkg::FS_SYNC: if (byte_done) fs <= ev_frame ? lfd_pkg::FS_PID : lfd_pkg::FS_IDLE;
        lfd_pkg::FS_PID:  if (byte_done) fs <= byte_ok ? lfd_pkg::FS_DATA : lfd_pkg::FS_IDLE;
        lfd_pkg::FS_DATA: if (end_frame) fs <= lfd_pkg::FS_IDLE;
        default:          fs <= lfd_pkg::FS_IDLE;
      endcase
    end
  end

  // running sums: classic over data only, enhanced seeded with the identifier byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pid_q <= 8'h00; sum_cls <= 8'h00; sum_enh <= 8'h00; prev_cls <= 8'h00;
      prev_enh <= 8'h00; last_byte <= 8'h00; nbytes <= 4'h0;
      id_hit_q <= 1'b0; data_ok_q <= 1'b0;
    end else if (fs == lfd_pkg::FS_PID && byte_ok) begin
      pid_q     <= shreg;
      sum_cls   <= 8'h00;
      sum_enh   <= shreg;
      nbytes    <= 4'h0;
      id_hit_q  <= id_hit;
      data_ok_q <= 1'b1;
    end else if (fs == lfd_pkg::FS_DATA && byte_ok && !full) begin
      prev_cls  <= sum_cls;
      prev_enh  <= sum_enh;
      sum_cls   <= lfd_addc(sum_cls, shreg);
      sum_enh   <= lfd_addc(sum_enh, shreg);
      last_byte <= shreg;
      nbytes    <= nbytes + 4'h1;
      data_ok_q <= all_hit;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  wire [31:0] last_w = {4'h0, nbytes, 6'h00, fs, last_byte, pid_q};
  wire [31:0] rd_mux = reg_addr == lfd_pkg::OFS_CTRL    ? ctrl :
                       reg_addr == lfd_pkg::OFS_BITDIV  ? {16'h0000, bitdiv} :
                       reg_addr == lfd_pkg::OFS_IDCFG   ? idcfg :
                       reg_addr == lfd_pkg::OFS_PAT_LO  ? pat_lo :
                       reg_addr == lfd_pkg::OFS_PAT_HI  ? pat_hi :
                       reg_addr == lfd_pkg::OFS_PMSK_LO ? pmsk_lo :
                       reg_addr == lfd_pkg::OFS_PMSK_HI ? pmsk_hi :
                       reg_addr == lfd_pkg::OFS_STATUS  ? {24'h00_0000, status} :
                       reg_addr == lfd_pkg::OFS_MASK    ? mask :
                       reg_addr == lfd_pkg::OFS_LAST    ? last_w : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 32'h0000_0000;
    else        reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_sync_stop;
    fs == lfd_pkg::FS_SYNC ##0 byte_ok ##0 shreg == lfd_pkg::SYNC_BYTE;
  endsequence
  sequence s_pid_taken;
    fs == lfd_pkg::FS_PID ##0 byte_ok;
  endsequence

  a_byte_stop: assert property (byte_valid |-> $past(lvl) && $past(bit_idx) == 4'h9)
    else $error("byte accepted without a high stop bit");
  a_lsb_first: assert property (samp && bit_idx == 4'h8 |=> shreg[7] == $past(lvl))
    else $error("last data bit not placed in the top bit");
  a_pid_split: assert property (s_pid_taken |=> pid_q == $past(shreg)
                                && fs == lfd_pkg::FS_DATA)
    else $error("identifier byte not captured");
  a_idle_start: assert property (en && !rx_busy && $fell(lvl) |=> rx_busy)
    else $error("falling edge from idle did not start a byte");
  a_wake_trig: assert property (mode == lfd_pkg::MODE_WAKE && ev_wake |=> trig
                                && status[lfd_pkg::ST_WAKE])
    else $error("wake-up did not trigger");
  a_error_flags: assert property (ev_par || ev_chk |=> ##1 irq ||
                                  (mask[lfd_pkg::ST_PAR] == 1'b0 && mask[lfd_pkg::ST_CHK] == 1'b0))
    else $error("unmasked error did not raise the interrupt");
  a_ver_classic: assert property (ver == lfd_pkg::VER_13 && end_frame
                                  && nbytes >= 4'h2 && ok_cls
                                  && !status[lfd_pkg::ST_CHK] |=> !status[lfd_pkg::ST_CHK])
    else $error("classic checksum wrongly flagged");
  a_enh_sum: assert property (ver == lfd_pkg::VER_21 && end_frame && !cls_id
                              && nbytes >= 4'h2 && !ok_enh |=> status[lfd_pkg::ST_CHK])
    else $error("enhanced checksum error not flagged");
  a_parity_bits: assert property (s_pid_taken ##0 shreg[7:6] != lfd_parity(shreg[5:0])
                                  |=> status[lfd_pkg::ST_PAR])
    else $error("parity error not flagged");
  a_start_stop: assert property (s_sync_stop |=> status[lfd_pkg::ST_FRAME]
                                 && fs == lfd_pkg::FS_PID)
    else $error("frame start not flagged at sync stop bit");
  a_id_six: assert property (s_pid_taken ##0 id_cnd == lfd_pkg::CND_EQ
                             && ((shreg[5:0] ^ id_val) & id_msk) == 6'h00 |-> ev_id)
    else $error("identifier compare looked beyond six bits");
  a_brk_sync: assert property (en && $rose(lvl) && run >= brk_thr
                               |=> fs == lfd_pkg::FS_SYNC && !rx_busy)
    else $error("break not followed by sync expectation");

endmodule

// file: verification/lfd_lin_node.sv
`timescale 1ns/1ps
module lfd_lin_node #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk,
  output logic      lin
);
  // ----------------------------------------------------------------
  // line driver, recessive high while idle
  // ----------------------------------------------------------------
  initial lin = 1'b1;
  // drive one level for exactly n cycles; callers stand just after a rising edge
  task automatic hold(input logic v, input int n);
    lin <= v;
    repeat (n) @(posedge clk);
  endtask
  // header opens with a long dominant break and a one-bit delimiter; only this master starts
  task automatic brk(input int nbits);
    hold(1'b0, nbits * BIT_CYC);
    hold(1'b1, BIT_CYC);
  endtask
  task automatic send(input logic [7:0] b);
    int i;
    hold(1'b0, BIT_CYC);
    for (i = 0; i < 8; i++) begin
      hold(b[i], BIT_CYC);
    end
    hold(1'b1, BIT_CYC);
  endtask
  task automatic idle(input int nbits);
    hold(1'b1, nbits * BIT_CYC);
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, arst_n = 1'b0, lin_rx, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, byte_data;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, v;
  logic        irq, trig, byte_valid;
  int          mismatches = 0, n_tests = 0, cyc = 0, ntrig = 0;
  logic [7:0]  got[$], exp_q[$];
  always #12.5 clk = ~clk;
  lfd_lin_node #(.BIT_CYC(16)) u_lfd_lin_node (.clk(clk), .lin(lin_rx));
  lfd_monitor #(.WAKE_MIN_CYC(20)) u_lfd_monitor (.clk(clk), .arst_n(arst_n),
    .lin_rx(lin_rx), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .trig(trig),
    .byte_data(byte_data), .byte_valid(byte_valid));
  always @(posedge clk) begin
    if (byte_valid === 1'b1) got.push_back(byte_data);
    if (trig === 1'b1) ntrig++;
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  // one frame: kind 0 classic sum, 1 bad checksum, 2 bad parity, 3 id and data match
  task automatic frame(input int kind);
    int id, n, s, i;
    logic [7:0] protected_identifier, d;
    logic [2:0] md, vr;
    id = $urandom_range(59, 0);
    n = $urandom_range(8, 1);
    protected_identifier = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id[5:0]};
    if (kind == 2) protected_identifier = protected_identifier ^ 8'hC0;
    exp_q = '{lfd_pkg::SYNC_BYTE, protected_identifier};
    s = (kind == 0) ? 0 : int'(protected_identifier);
    for (i = 0; i < n; i++) begin
      d = 8'($urandom_range(255, 0));
      exp_q.push_back(d);
      s = s + d;
      if (s > 255) s = s - 255;
    end
    d = ~s[7:0] ^ ((kind == 1) ? 8'h01 : 8'h00);
    exp_q.push_back(d);
    md = kind == 0 ? lfd_pkg::MODE_FRAME :
         kind == 3 ? lfd_pkg::MODE_IDDATA : lfd_pkg::MODE_ERROR;
    vr = kind == 0 ? lfd_pkg::VER_13 :
         kind == 3 ? lfd_pkg::VER_ANY : 3'(lfd_pkg::VER_20 + 3'(kind));
    wr(lfd_pkg::OFS_PAT_LO, 32'(exp_q[2]));
    wr(lfd_pkg::OFS_PMSK_LO, 32'h0000_00FF);
    wr(lfd_pkg::OFS_IDCFG, 32'h0000_3F00 | 32'(id) | (kind == 3 ? 32'h0100_0000 : 32'h0));
    wr(lfd_pkg::OFS_CTRL, 32'h1 | 32'(md) << 1 | 32'(vr) << 4
       | (kind ? 32'h0000_0380 : 32'h0));
    got.delete();
    ntrig = 0;
    u_lfd_lin_node.brk(13);
    foreach (exp_q[j]) u_lfd_lin_node.send(exp_q[j]);
    u_lfd_lin_node.idle(12);
    check("byte count", got.size(), exp_q.size());
    foreach (exp_q[j]) check("byte", got[j], exp_q[j]);
    check("trig count", ntrig, 1);
    rd(lfd_pkg::OFS_STATUS, v);
    // frame start, id match on six bits, data match, checksum and parity flags
    check("status", v & 32'hB7, 32'h83 | (kind == 1 ? 32'h10 : 32'h0)
          | (kind == 2 ? 32'h20 : 32'h0) | (kind == 3 ? 32'h04 : 32'h0));
    check("irq", irq, 1'b1);
    wr(lfd_pkg::OFS_MASK, 32'h0);
    repeat (2) @(posedge clk);
    check("irq masked", irq, 1'b0);
    wr(lfd_pkg::OFS_MASK, 32'hFF);
    wr(lfd_pkg::OFS_STATUS, 32'hFF);
    rd(lfd_pkg::OFS_STATUS, v);
    check("status clear", v, 32'h0);
    repeat (2) @(posedge clk);
    check("irq clear", irq, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(51));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(lfd_pkg::OFS_CTRL, v);
    check("ctrl reset", v, lfd_pkg::CTRL_RST);
    rd(lfd_pkg::OFS_BITDIV, v);
    check("bitdiv reset", v, {16'h0000, lfd_pkg::BITDIV_RST});
    rd(lfd_pkg::OFS_IDCFG, v);
    check("idcfg reset", v, lfd_pkg::IDCFG_RST);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, v);
    check("unmapped", v, 32'h0);
    wr(lfd_pkg::OFS_BITDIV, 32'h0000_0010);
    wr(lfd_pkg::OFS_MASK, 32'hFF);
    for (int k = 0; k < 4; k++) frame(k);
    wr(lfd_pkg::OFS_CTRL, 32'h1 | 32'(lfd_pkg::MODE_WAKE) << 1);
    ntrig = 0;
    u_lfd_lin_node.hold(1'b0, 40);
    u_lfd_lin_node.idle(2);
    rd(lfd_pkg::OFS_STATUS, v);
    check("wake status", v & 32'h88, 32'h88);
    check("wake trig", ntrig, 1);
    test_done();
  end
endmodule
